// ==== hdl/ffos_flag_offset_status.sv ====
// Function
// - Master reset loads both offsets from load_select and the two offset selects.
// - load_select at master reset is latched into serialMode; offsets are programmed over offsetData in parallel in either mode.
// - Separate empty offset n and full offset m drive the two almost flags.
// - Offsets read back only over the parallel data_out port, either mode.
// - Offsets may be programmed or reprogrammed after master reset, but only while load_select is low.
// - Synchronous mode: almost_full_flag updates only on write-side edges.
// - Synchronous mode: almost_empty_flag updates only on read-side edges.
// - Asynchronous mode: almost_full set low by write, released high by read.
// - Asynchronous mode: almost_empty set low by read, released high by write.
// - One to n words: empty high, almost-empty low, others high.
// - Half depth plus one to depth minus m plus one: half-full low.
// - almost_empty_flag goes high once the count reaches n plus one.
// - almost_full_flag low from depth minus m, including while full.
// - At full depth full_flag goes low and writes are blocked.
// - When empty, empty_flag goes low and reads are ignored.
`timescale 1ns/1ns
`default_nettype none

module ffos_flag_offset_status #(
    parameter int DEPTH = ffos_pkg::DEPTH_DEFAULT,
    parameter int CW    = $clog2(DEPTH) + 1
) (
    // Clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            rst,
    // Configuration straps and master reset
    input  wire logic                            master_reset,
    input  wire logic                            load_select,
    input  wire logic                            offset_select1,
    input  wire logic                            offset_select0,
    input  wire logic                            flag_timing_select,
    // FIFO core strobes
    input  wire logic                            writeReq,
    input  wire logic                            readReq,
    // Offset programming and readback
    input  wire logic                            offsetWrite,
    input  wire logic                            offsetRead,
    input  wire logic                            offsetWhich,
    input  wire logic [ffos_pkg::OFFSET_W-1:0]   offsetData,
    // Status outputs, active low
    output logic                                 empty_flag,
    output logic                                 almost_empty_flag,
    output logic                                 half_full_flag,
    output logic                                 almost_full_flag,
    output logic                                 full_flag,
    // Core strobes qualified by flags
    output logic                                 writeAccept,
    output logic                                 readAccept,
    // Mode and readback
    output logic                                 serialMode,
    output logic                                 syncFlagMode,
    output logic      [ffos_pkg::OFFSET_W-1:0]   data_out,
    output logic      [CW-1:0]                   wordCount
);

    // ==========================================
    // Default offset decode
    // ==========================================
    logic [ffos_pkg::OFFSET_W-1:0] defaultOffset;
    logic [ffos_pkg::OFFSET_W-1:0] emptyOffset;
    logic [ffos_pkg::OFFSET_W-1:0] fullOffset;
    logic                          wrGo;
    logic                          rdGo;
    logic [CW-1:0]                 next_count;

    ffos_default_rom u_rom (
        .sel    ({load_select, offset_select1, offset_select0}),
        .offset (defaultOffset)
    );

    // ==========================================
    // Offsets and mode straps
    // ==========================================
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            emptyOffset  <= ffos_pkg::OFS_LLL;
            fullOffset   <= ffos_pkg::OFS_LLL;
            serialMode   <= 1'b0;
            syncFlagMode <= 1'b0;
        end else if (master_reset) begin
            emptyOffset  <= defaultOffset;
            fullOffset   <= defaultOffset;
            serialMode   <= load_select;
            syncFlagMode <= flag_timing_select;
        end else if (offsetWrite && !load_select) begin
            if (offsetWhich == ffos_pkg::FFOS_SEL_FULL) begin
                fullOffset <= offsetData;
            end else begin
                emptyOffset <= offsetData;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data_out <= '0;
        end else if (offsetRead && !load_select && !master_reset) begin
            data_out <= (offsetWhich == ffos_pkg::FFOS_SEL_FULL) ? fullOffset : emptyOffset;
        end
    end

    // ==========================================
    // Word count and strobe gating
    // ==========================================
    always_comb begin
        wrGo = writeReq && load_select && full_flag;
        rdGo = readReq && load_select && empty_flag;
        next_count = wordCount;
        if (wrGo && !rdGo) begin
            next_count = wordCount + CW'(1);
        end else if (rdGo && !wrGo) begin
            next_count = wordCount - CW'(1);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wordCount   <= '0;
            writeAccept <= 1'b0;
            readAccept  <= 1'b0;
        end else if (master_reset) begin
            wordCount   <= '0;
            writeAccept <= 1'b0;
            readAccept  <= 1'b0;
        end else begin
            wordCount   <= next_count;
            writeAccept <= wrGo;
            readAccept  <= rdGo;
        end
    end

    // ==========================================
    // Status flags from the next count
    // ==========================================
    // Thresholds are compared one bit wider than both the count and the
    // offsets, so a default offset larger than a small depth cannot wrap.
    localparam int MW = ((CW > ffos_pkg::OFFSET_W) ? CW : ffos_pkg::OFFSET_W) + 1;

    logic [CW-1:0] halfMark;
    logic [CW-1:0] depthCw;
    logic [MW-1:0] countWide;
    logic          aeLevel;
    logic          afLevel;

    always_comb begin
        depthCw   = CW'(DEPTH);
        halfMark  = CW'(DEPTH / 2);
        countWide = MW'(next_count);
        aeLevel   = countWide > MW'(emptyOffset);
        afLevel   = (countWide + MW'(fullOffset)) < MW'(DEPTH);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            empty_flag     <= 1'b0;
            half_full_flag <= 1'b1;
            full_flag      <= 1'b1;
        end else if (master_reset) begin
            empty_flag     <= 1'b0;
            half_full_flag <= 1'b1;
            full_flag      <= 1'b1;
        end else begin
            empty_flag     <= next_count != '0;
            half_full_flag <= !(next_count > halfMark);
            full_flag      <= next_count != depthCw;
        end
    end

    // Synchronous mode samples the level only on its own strobe, so the flags may
    // lag the count; asynchronous mode sets on one strobe and releases on the other.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            almost_empty_flag <= 1'b0;
            almost_full_flag  <= 1'b1;
        end else if (master_reset) begin
            almost_empty_flag <= 1'b0;
            almost_full_flag  <= 1'b1;
        end else if (syncFlagMode) begin
            if (wrGo) begin
                almost_full_flag <= afLevel;
            end
            if (rdGo) begin
                almost_empty_flag <= aeLevel;
            end
        end else begin
            if (wrGo && !afLevel) begin
                almost_full_flag <= 1'b0;
            end else if (rdGo && afLevel) begin
                almost_full_flag <= 1'b1;
            end
            if (rdGo && !aeLevel) begin
                almost_empty_flag <= 1'b0;
            end else if (wrGo && aeLevel) begin
                almost_empty_flag <= 1'b1;
            end
        end
    end

    // ==========================================
    // Checks
    // ==========================================
    a_full_blocks: assert property (@(posedge core_clk) disable iff (rst)
        !full_flag |-> !wrGo) else $error("write taken while full");
    a_empty_blocks: assert property (@(posedge core_clk) disable iff (rst)
        !empty_flag |-> !rdGo) else $error("read taken while empty");
    a_full_count: assert property (@(posedge core_clk) disable iff (rst || master_reset)
        ##1 (full_flag == (wordCount != CW'(DEPTH)))) else $error("full flag mismatch");
    a_empty_count: assert property (@(posedge core_clk) disable iff (rst || master_reset)
        ##1 (empty_flag == (wordCount != '0))) else $error("empty flag mismatch");
    a_half_count: assert property (@(posedge core_clk) disable iff (rst || master_reset)
        ##1 (half_full_flag == (wordCount <= CW'(DEPTH / 2)))) else $error("half flag mismatch");
    a_default_load: assert property (@(posedge core_clk) disable iff (rst)
        master_reset |=> (emptyOffset == $past(defaultOffset)) && (fullOffset == emptyOffset))
        else $error("default offset not loaded");
    a_mode_latch: assert property (@(posedge core_clk) disable iff (rst)
        master_reset |=> serialMode == $past(load_select)) else $error("mode not latched");
    a_af_sync: assert property (@(posedge core_clk) disable iff (rst || master_reset)
        syncFlagMode && !wrGo |=> $stable(almost_full_flag)) else $error("almost full moved");
    a_ae_sync: assert property (@(posedge core_clk) disable iff (rst || master_reset)
        syncFlagMode && !rdGo |=> $stable(almost_empty_flag)) else $error("almost empty moved");
    sequence s_af_rise_no_read;
        !syncFlagMode && !rdGo ##1 $rose(almost_full_flag);
    endsequence

    sequence s_ae_rise_no_write;
        !syncFlagMode && !wrGo ##1 $rose(almost_empty_flag);
    endsequence

    a_af_async: assert property (@(posedge core_clk) disable iff (rst || master_reset)
        s_af_rise_no_read |-> 1'b0)
        else $error("almost full released without read");
    a_ae_async: assert property (@(posedge core_clk) disable iff (rst || master_reset)
        s_ae_rise_no_write |-> 1'b0)
        else $error("almost empty released without write");

endmodule : ffos_flag_offset_status

`default_nettype wire

// ==== hdl/ffos_pkg.sv ====
package ffos_pkg;

    // ==========================================
    // Default offset selection
    // ==========================================
    localparam int OFFSET_W = 17;
    localparam int DEPTH_DEFAULT = 16384;
    localparam int WORD_W = 72;

    localparam logic [OFFSET_W-1:0] OFS_LLL = 17'h0007f;
    localparam logic [OFFSET_W-1:0] OFS_HLL = 17'h003ff;
    localparam logic [OFFSET_W-1:0] OFS_LHL = 17'h001ff;
    localparam logic [OFFSET_W-1:0] OFS_LLH = 17'h000ff;
    localparam logic [OFFSET_W-1:0] OFS_LHH = 17'h0003f;
    localparam logic [OFFSET_W-1:0] OFS_HHL = 17'h0001f;
    localparam logic [OFFSET_W-1:0] OFS_HLH = 17'h0000f;
    localparam logic [OFFSET_W-1:0] OFS_HHH = 17'h00007;

    // Selection code is {load_select, offset_select1, offset_select0}.
    localparam logic [2:0] SEL_LLL = 3'h0;
    localparam logic [2:0] SEL_LLH = 3'h1;
    localparam logic [2:0] SEL_LHL = 3'h2;
    localparam logic [2:0] SEL_LHH = 3'h3;
    localparam logic [2:0] SEL_HLL = 3'h4;
    localparam logic [2:0] SEL_HLH = 3'h5;
    localparam logic [2:0] SEL_HHL = 3'h6;
    localparam logic [2:0] SEL_HHH = 3'h7;

    // ==========================================
    // Offset port access
    // ==========================================
    typedef enum logic {
        FFOS_SEL_EMPTY,
        FFOS_SEL_FULL
    } ffos_which_e;

endpackage : ffos_pkg

// ==== hdl/ffos_default_rom.sv ====
`timescale 1ns/1ns
`default_nettype none

module ffos_default_rom (
    // Selection pins
    input  wire logic [2:0]                      sel,
    // Chosen default
    output logic      [ffos_pkg::OFFSET_W-1:0]   offset
);

    always_comb begin
        unique case (sel)
            ffos_pkg::SEL_LLL: offset = ffos_pkg::OFS_LLL;
            ffos_pkg::SEL_HLL: offset = ffos_pkg::OFS_HLL;
            ffos_pkg::SEL_LHL: offset = ffos_pkg::OFS_LHL;
            ffos_pkg::SEL_LLH: offset = ffos_pkg::OFS_LLH;
            ffos_pkg::SEL_LHH: offset = ffos_pkg::OFS_LHH;
            ffos_pkg::SEL_HHL: offset = ffos_pkg::OFS_HHL;
            ffos_pkg::SEL_HLH: offset = ffos_pkg::OFS_HLH;
            ffos_pkg::SEL_HHH: offset = ffos_pkg::OFS_HHH;
        endcase
    end

endmodule : ffos_default_rom

`default_nettype wire

// ==== verif/ffos_far_side.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Writer and reader traffic source
// ==========================================
module ffos_far_side (
    // Clock
    input  wire logic       core_clk,
    // Traffic control
    input  wire logic       dataPhase,
    input  wire logic [7:0] wrPct,
    input  wire logic [7:0] rdPct,
    // Strobes toward the flag block
    output logic            writeReq,
    output logic            readReq
);
    initial begin
        writeReq = 1'b0;
        readReq  = 1'b0;
    end
    // Requests move only after a falling edge and stay put over the next rising edge.
    always @(negedge core_clk) begin
        writeReq <= dataPhase && (($urandom % 100) < wrPct);
        readReq  <= dataPhase && (($urandom % 100) < rdPct);
    end
endmodule : ffos_far_side
`default_nettype wire

// ==== verif/ffos_flag_offset_status_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module ffos_flag_offset_status_bench;
    localparam int D  = 32;
    localparam int CW = $clog2(D) + 1;
    logic core_clk, rst, masterReset, loadSelect, offsetSel1, offsetSel0, flagTiming;
    logic writeReq, readReq, offsetWrite, offsetRead, offsetWhich, dataPhase;
    logic [ffos_pkg::OFFSET_W-1:0] offsetData, dataOut;
    logic emptyFlag, almostEmpty, halfFull, almostFull, fullFlag, serialMode, syncFlagMode;
    logic writeAccept, readAccept, afX, aeX, prevW, prevR, syncMode, chk;
    logic [7:0]    wrPct, rdPct;
    logic [CW-1:0] wordCount;
    int count, n, m, n_mismatch, checked;
    int defTab[8] = '{127, 255, 511, 63, 1023, 15, 31, 7};
    wire wrGo = writeReq && loadSelect && count < D;
    wire rdGo = readReq && loadSelect && count > 0;

    ffos_flag_offset_status #(.DEPTH(D)) ffos_flag_offset_status_inst (
        .core_clk(core_clk), .rst(rst), .master_reset(masterReset),
        .load_select(loadSelect), .offset_select1(offsetSel1), .offset_select0(offsetSel0),
        .flag_timing_select(flagTiming), .writeReq(writeReq), .readReq(readReq),
        .offsetWrite(offsetWrite), .offsetRead(offsetRead), .offsetWhich(offsetWhich),
        .offsetData(offsetData), .empty_flag(emptyFlag), .almost_empty_flag(almostEmpty),
        .half_full_flag(halfFull), .almost_full_flag(almostFull), .full_flag(fullFlag),
        .writeAccept(writeAccept), .readAccept(readAccept), .serialMode(serialMode),
        .syncFlagMode(syncFlagMode), .data_out(dataOut), .wordCount(wordCount));
    ffos_far_side ffos_far_side_inst (.core_clk(core_clk), .dataPhase(dataPhase),
        .wrPct(wrPct), .rdPct(rdPct), .writeReq(writeReq), .readReq(readReq));

    // ==========================================
    // Reference count and flag expectations
    // ==========================================
    always @(posedge core_clk or posedge rst) begin
        if (rst || masterReset) begin
            count = 0;
            afX = 1'b1;
            aeX = 1'b0;
            prevW = 1'b0;
            prevR = 1'b0;
        end else begin
            prevW = wrGo;
            prevR = rdGo;
            count = count + int'(prevW) - int'(prevR);
            if (syncMode) begin
                if (prevW) afX = !(count >= D - m);
                if (prevR) aeX = count > n;
            end else begin
                if (prevW && count >= D - m) afX = 1'b0;
                else if (prevR && count < D - m) afX = 1'b1;
                if (prevR && count <= n) aeX = 1'b0;
                else if (prevW && count > n) aeX = 1'b1;
            end
        end
    end
    task automatic check(input logic ok, input string what);
        checked++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : check
    always @(negedge core_clk) begin
        if (chk) begin
            check(wordCount === CW'(count), "word count");
            check(emptyFlag === (count != 0), "empty flag");
            check(almostEmpty === aeX, "almost empty flag");
            check(halfFull === !(count > D / 2), "half full flag");
            check(almostFull === afX, "almost full flag");
            check(fullFlag === (count != D), "full flag");
            check(writeAccept === prevW && readAccept === prevR, "accept");
        end
    end
    // ==========================================
    // Stimulus tasks
    // ==========================================
    task automatic mreset(input logic [2:0] code, input logic sync);
        @(negedge core_clk);
        masterReset <= 1'b1;
        {loadSelect, offsetSel1, offsetSel0} <= code;
        flagTiming <= sync;
        @(negedge core_clk);
        masterReset <= 1'b0;
        loadSelect <= 1'b0;
        n = defTab[code];
        m = defTab[code];
        syncMode = sync;
        @(negedge core_clk);
        check(serialMode === code[2] && syncFlagMode === sync, "straps");
    endtask : mreset
    task automatic readOff(input logic which, input int exp);
        @(negedge core_clk);
        offsetRead <= 1'b1;
        offsetWhich <= which;
        @(negedge core_clk);
        offsetRead <= 1'b0;
        check(dataOut === ffos_pkg::OFFSET_W'(exp), "offset readback");
    endtask : readOff
    task automatic writeOff(input logic which, input int val);
        @(negedge core_clk);
        offsetWrite <= 1'b1;
        offsetWhich <= which;
        offsetData <= ffos_pkg::OFFSET_W'(val);
        @(negedge core_clk);
        offsetWrite <= 1'b0;
        if (which) m = val;
        else n = val;
    endtask : writeOff
    task automatic traffic(input int wp, input int rp, input int cycles);
        @(negedge core_clk);
        loadSelect <= 1'b1;
        dataPhase <= 1'b1;
        wrPct <= 8'(wp);
        rdPct <= 8'(rp);
        repeat (cycles) @(negedge core_clk);
        dataPhase <= 1'b0;
        @(negedge core_clk);
        loadSelect <= 1'b0;
    endtask : traffic
    task automatic end_of_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    // ==========================================
    // Clock, watchdog and main sequence
    // ==========================================
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        #(40 * 8000);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {rst, masterReset, loadSelect, offsetSel1, offsetSel0, flagTiming} = 6'h20;
        {offsetWrite, offsetRead, offsetWhich, dataPhase, chk, syncMode} = 6'h00;
        {afX, aeX, prevW, prevR} = 4'h8;
        offsetData = '0;
        wrPct = 8'h00;
        rdPct = 8'h00;
        void'($urandom(77));
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        chk = 1'b1;
        for (int code = 0; code < 8; code++) begin
            mreset(3'(code), 1'(code));
            readOff(1'b0, defTab[code]);
            readOff(1'b1, defTab[code]);
        end
        for (int s = 0; s < 2; s++) begin
            mreset(3'h7, 1'(s));
            writeOff(1'b0, 5);
            writeOff(1'b1, 4);
            readOff(1'b0, 5);
            readOff(1'b1, 4);
            traffic(90, 10, 150);
            traffic(10, 90, 150);
            writeOff(1'b0, $urandom % D);
            writeOff(1'b1, $urandom % D);
            traffic(60, 50, 300);
            writeOff(1'b0, 0);
            writeOff(1'b1, D - 1);
            traffic(70, 40, 200);
        end
        end_of_test();
    end
endmodule : ffos_flag_offset_status_bench
`default_nettype wire
